// file: hw/dcr_device.sv
// DAC control register layer, device end
//
// Operation
// R1 - control writes: group bits 111, select D15-D13
// R2 - select decodes slew, global, channel, boost, software
// R3 - polarity bit resets 0, inverts polarity pin
// R4 - D11 enables status echo on writes
// R5 - D10 switches interface watchdog on
// R6 - D9-D8 pick 5, 10, 100, 200 ms
// R7 - D6 short limit: 0=15mA, 1=8mA
// R8 - D5 enables all four outputs together
// R9 - D4 powers all four boosts together
// R10 - channel D8 powers channel core, not output
// R11 - channel D7 lets clear input load channel
// R12 - channel D6 enables that channel output
// R13 - channel D5: 0 external, 1 internal resistor
// R14 - channel D4 powers channel boost converter
// R15 - channel D3 adds 20% voltage over-range
// R16 - range code D2-D0 selects output span
// R17 - channel address picks target of channel write
// R18 - top bit one means read, not write
// R19 - other bits reset zero, don't-cares ignored
`timescale 1ns/1ps
`include "dcr_defines.svh"
module dcr_device
	import dcr_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	dcr_if.dev               link,
	input  wire logic        polarity_pin_i,
	input  wire logic        clear_i,
	output logic             output_polarity_choice_o,
	output logic             status_echo_enable_o,
	output logic             link_timeout_enable_o,
	output logic [1:0]       timeout_select_o,
	output logic [7:0]       timeout_ms_o,
	output logic             short_limit_select_o,
	output logic [4:0]       short_limit_ma_o,
	output logic [3:0]       channel_power_o,
	output logic [3:0]       clear_participation_o,
	output logic [3:0]       channel_output_on_o,
	output logic [3:0]       sense_resistor_select_o,
	output logic [3:0]       channel_boost_power_o,
	output logic [3:0]       extra_span_enable_o,
	output logic [11:0]      range_select_o,
	output logic [3:0]       voltage_pin_level_o,
	output logic [3:0]       clear_load_o,
	output logic             read_request_o,
	output logic [4:0]       read_select_o,
	output logic             aux_write_o,
	output logic [2:0]       aux_select_o,
	output logic [1:0]       aux_channel_o,
	output logic [15:0]      aux_data_o
);

	logic [15:0] global_configuration;
	logic [15:0] channel_configuration [4];
	logic        is_write;
	logic        is_ctrl;
	logic [2:0]  sel;
	logic [1:0]  chan;
	logic [15:0] payload;

	// Always ready: one word per cycle
	assign link.word_ready = 1'b1;

	////////////////////////////////////////////////////////////////////
	// Word decode
	assign is_write = link.word_valid && !link.word_data[`DCR_RW_BIT]; // R18
	assign is_ctrl  = link.word_data[`DCR_GRP_HI:`DCR_GRP_LO] == `DCR_GRP_CONTROL; // R1
	assign sel      = link.word_data[`DCR_SEL_HI:`DCR_SEL_LO]; // R1
	assign chan     = link.word_data[`DCR_CHAN_HI:`DCR_CHAN_LO];
	assign payload  = link.word_data[15:0];

	////////////////////////////////////////////////////////////////////
	// Global configuration register
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			global_configuration <= `DCR_G_RESET; // R3
		end else if (is_write && is_ctrl && sel == `DCR_SEL_GLOBAL) begin // R2
			global_configuration <= payload & `DCR_G_MASK; // R19
		end
	end

	// Channel configuration registers
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < 4; i++) begin
				channel_configuration[i] <= `DCR_C_RESET; // R19
			end
		end else if (is_write && is_ctrl && sel == `DCR_SEL_CHANNEL) begin // R2
			channel_configuration[chan] <= payload & `DCR_C_MASK; // R17
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pass slew, boost and software selects of control writes to neighbouring logic
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			aux_write_o   <= 1'b0;
			aux_select_o  <= 3'h0;
			aux_channel_o <= 2'h0;
			aux_data_o    <= 16'h0000;
		end else begin
			aux_write_o   <= is_write && is_ctrl && (sel == `DCR_SEL_SLEW
				|| sel == `DCR_SEL_BOOST || sel == `DCR_SEL_SOFTWARE); // R2
			aux_select_o  <= sel;
			aux_channel_o <= chan;
			aux_data_o    <= payload;
		end
	end

	// Read requests: register select in D20-D16
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			read_request_o <= 1'b0;
			read_select_o  <= 5'h00;
		end else begin
			read_request_o <= link.word_valid && link.word_data[`DCR_RW_BIT]; // R18
			if (link.word_valid && link.word_data[`DCR_RW_BIT]) begin
				read_select_o <= link.word_data[20:16];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Global fields
	assign output_polarity_choice_o = global_configuration[`DCR_G_POL]; // R3
	assign status_echo_enable_o     = global_configuration[`DCR_G_ECHO]; // R4
	assign link_timeout_enable_o    = global_configuration[`DCR_G_WDEN]; // R5
	assign timeout_select_o         = global_configuration[`DCR_G_WD_HI:`DCR_G_WD_LO];
	assign short_limit_select_o     = global_configuration[`DCR_G_SHORT]; // R7
	assign short_limit_ma_o         = short_limit_select_o ? 5'(`DCR_SHORT_MA_1)
		: 5'(`DCR_SHORT_MA_0); // R7

	// Watchdog period lookup
	always_comb begin
		case (timeout_select_o) // R6
			2'h0:    timeout_ms_o = 8'(`DCR_WD_MS_0);
			2'h1:    timeout_ms_o = 8'(`DCR_WD_MS_1);
			2'h2:    timeout_ms_o = 8'(`DCR_WD_MS_2);
			default: timeout_ms_o = 8'(`DCR_WD_MS_3);
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Per-channel fields, merged with global enables
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			channel_power_o[i]         = channel_configuration[i][`DCR_C_POWER]; // R10
			clear_participation_o[i]   = channel_configuration[i][`DCR_C_CLEAR];
			channel_output_on_o[i]     = channel_configuration[i][`DCR_C_OUT] // R12
				| global_configuration[`DCR_G_ALLOUT]; // R8
			sense_resistor_select_o[i] = channel_configuration[i][`DCR_C_RSNS]; // R13
			channel_boost_power_o[i]   = channel_configuration[i][`DCR_C_BOOST] // R14
				| global_configuration[`DCR_G_ALLBOOST]; // R9
			range_select_o[i*3 +: 3]   =
				channel_configuration[i][`DCR_C_RNG_HI:`DCR_C_RNG_LO]; // R16
			// Over-range only on voltage codes
			extra_span_enable_o[i]     = channel_configuration[i][`DCR_C_SPAN]
				& ~channel_configuration[i][`DCR_C_RNG_HI]; // R15
			clear_load_o[i]            = clear_i & clear_participation_o[i]; // R11
			voltage_pin_level_o[i]     = polarity_pin_i ^ output_polarity_choice_o; // R3
		end
	end

endmodule

// file: shared/dcr_defines.svh
// Bit positions, codes and reset values of the DAC control register layer
`ifndef DCR_DEFINES_SVH
`define DCR_DEFINES_SVH

`define DCR_WORD_W        24
`define DCR_RW_BIT        23
`define DCR_CHIP_HI       22
`define DCR_CHIP_LO       21
`define DCR_GRP_HI        20
`define DCR_GRP_LO        18
`define DCR_CHAN_HI       17
`define DCR_CHAN_LO       16
`define DCR_SEL_HI        15
`define DCR_SEL_LO        13
`define DCR_GRP_CONTROL   3'h7
`define DCR_SEL_SLEW      3'h0
`define DCR_SEL_GLOBAL    3'h1
`define DCR_SEL_CHANNEL   3'h2
`define DCR_SEL_BOOST     3'h3
`define DCR_SEL_SOFTWARE  3'h4
// Global configuration fields
`define DCR_G_POL         12
`define DCR_G_ECHO        11
`define DCR_G_WDEN        10
`define DCR_G_WD_HI       9
`define DCR_G_WD_LO       8
`define DCR_G_SHORT       6
`define DCR_G_ALLOUT      5
`define DCR_G_ALLBOOST    4
`define DCR_G_MASK        16'h1F70
`define DCR_G_RESET       16'h0000
// Channel configuration fields
`define DCR_C_POWER       8
`define DCR_C_CLEAR       7
`define DCR_C_OUT         6
`define DCR_C_RSNS        5
`define DCR_C_BOOST       4
`define DCR_C_SPAN        3
`define DCR_C_RNG_HI      2
`define DCR_C_RNG_LO      0
`define DCR_C_MASK        16'h01FF
`define DCR_C_RESET       16'h0000
// Watchdog periods in ms for codes 00..11
`define DCR_WD_MS_0       5
`define DCR_WD_MS_1       10
`define DCR_WD_MS_2       100
`define DCR_WD_MS_3       200
// Short limit in mA for select 0 and 1
`define DCR_SHORT_MA_0    15
`define DCR_SHORT_MA_1    8
`define DCR_SPAN_PCT      20

`endif

// file: shared/dcr_pkg.sv
// Types of the DAC control register layer
package dcr_pkg;
	typedef enum logic [2:0] {
		DCR_RNG_V5,
		DCR_RNG_V10,
		DCR_RNG_RSVD,
		DCR_RNG_VPM10,
		DCR_RNG_I4_20,
		DCR_RNG_I0_20,
		DCR_RNG_I0_24,
		DCR_RNG_RSVD7
	} dcr_range_e;
	typedef enum logic [1:0] {
		DCR_IDLE,
		DCR_SEND
	} dcr_state_e;
endpackage

// file: shared/dcr_if.sv
// Word link between host controller and DAC control register layer
`timescale 1ns/1ps
interface dcr_if;
	logic        word_valid;
	logic [23:0] word_data;
	logic        word_ready;
	modport host (output word_valid, output word_data, input word_ready);
	modport dev  (input word_valid, input word_data, output word_ready);
endinterface

// file: hw/dcr_host.sv
// Host controller end: frames configuration writes onto the word link
`timescale 1ns/1ps
`include "dcr_defines.svh"
module dcr_host
	import dcr_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	dcr_if.host              link,
	input  wire logic        cmd_valid_i,
	output logic             cmd_ready_o,
	input  wire logic        cmd_read_i,
	input  wire logic [1:0]  cmd_chip_i,
	input  wire logic [1:0]  cmd_channel_i,
	input  wire logic [2:0]  cmd_select_i,
	input  wire logic [12:0] cmd_data_i,
	input  wire logic [4:0]  cmd_read_select_i,
	output logic             cmd_done_o
);

	dcr_state_e  state;
	logic [23:0] word;

	// Build write word (R1, R18) or read word
	function automatic logic [23:0] dcr_frame(input logic rd, input logic [1:0] chip,
		input logic [1:0] ch, input logic [2:0] s, input logic [12:0] d,
		input logic [4:0] rs);
		if (rd) begin
			dcr_frame = {1'b1, chip, rs, 16'h0000}; // R18
		end else begin
			dcr_frame = {1'b0, chip, `DCR_GRP_CONTROL, ch, s, d}; // R1
		end
	endfunction

	assign cmd_ready_o     = state == DCR_IDLE;
	assign link.word_valid = state == DCR_SEND;
	assign link.word_data  = word;

	// Hold one word until the device takes it
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state      <= DCR_IDLE;
			word       <= 24'h00_0000;
			cmd_done_o <= 1'b0;
		end else begin
			cmd_done_o <= 1'b0;
			case (state)
				DCR_IDLE: begin
					if (cmd_valid_i) begin
						word  <= dcr_frame(cmd_read_i, cmd_chip_i, cmd_channel_i,
							cmd_select_i, cmd_data_i, cmd_read_select_i);
						state <= DCR_SEND;
					end
				end
				DCR_SEND: begin
					if (link.word_ready) begin
						state      <= DCR_IDLE;
						cmd_done_o <= 1'b1;
					end
				end
				default: state <= DCR_IDLE;
			endcase
		end
	end

endmodule

// file: tb/dcr_props.sv
// Link checks between the host and device ends
`timescale 1ns/1ps
module dcr_props (
	input wire logic        clk_i,
	input wire logic        sys_rst_i,
	input wire logic        word_valid,
	input wire logic [23:0] word_data,
	input wire logic        word_ready
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	////////////////////////////////////////////////////////////////
	// Framing of each word on the link
	ready_high_a: assert property (word_ready)
		else $error("device end not ready");
	valid_pulse_a: assert property (word_valid |=> !word_valid)
		else $error("word valid held too long");
	write_group_a: assert property (word_valid && !word_data[23]
		|-> word_data[20:18] == 3'h7)
		else $error("write without control group");
	select_legal_a: assert property (word_valid && !word_data[23]
		|-> word_data[15:13] <= 3'h4)
		else $error("control select out of range");
	read_payload_a: assert property (word_valid && word_data[23]
		|-> word_data[15:0] == 16'h0000)
		else $error("read word carries payload");
	reset_quiet_a: assert property ($fell(sys_rst_i) |-> !word_valid)
		else $error("word sent straight out of reset");
	// A new word only appears while it is offered
	word_settled_a: assert property ($changed(word_data) |-> word_valid)
		else $error("word changed while not offered");
endmodule

// file: tb/dac_control_register_decode_tb_top.sv
// Bench joining host and device ends, checked against a model
`timescale 1ns/1ps
module dac_control_register_decode_tb_top;
	logic        clk_i = 0, sys_rst_i = 1, cv = 0, crd = 0, pin = 0, clr = 0;
	logic [1:0]  cchip = 0, cch = 0, tsel, ach;
	logic [2:0]  csel = 0, asel;
	logic [12:0] cdat = 0;
	logic [4:0]  crs = 0, sma, rsel;
	logic        pol, echo, wden, shs, rrq, aw, crdy, cdone;
	logic [7:0]  tms;
	logic [3:0]  pwr, clp, outn, rsn, bst, spn, vpin, cld;
	logic [11:0] rng;
	logic [15:0] adat;
	int          n_mismatch = 0, tests_run = 0, g, c[4], i;
	int          wd[4] = '{5, 10, 100, 200};
	dcr_if lk();
	dcr_host i_dcr_host (.clk_i, .sys_rst_i, .link(lk.host), .cmd_valid_i(cv),
		.cmd_ready_o(crdy), .cmd_read_i(crd), .cmd_chip_i(cchip), .cmd_channel_i(cch),
		.cmd_select_i(csel), .cmd_data_i(cdat), .cmd_read_select_i(crs), .cmd_done_o(cdone));
	dcr_device i_dcr_device (.clk_i, .sys_rst_i, .link(lk.dev), .polarity_pin_i(pin),
		.clear_i(clr), .output_polarity_choice_o(pol), .status_echo_enable_o(echo),
		.link_timeout_enable_o(wden), .timeout_select_o(tsel), .timeout_ms_o(tms),
		.short_limit_select_o(shs), .short_limit_ma_o(sma), .channel_power_o(pwr),
		.clear_participation_o(clp), .channel_output_on_o(outn),
		.sense_resistor_select_o(rsn), .channel_boost_power_o(bst),
		.extra_span_enable_o(spn), .range_select_o(rng), .voltage_pin_level_o(vpin),
		.clear_load_o(cld), .read_request_o(rrq), .read_select_o(rsel),
		.aux_write_o(aw), .aux_select_o(asel), .aux_channel_o(ach), .aux_data_o(adat));
	dcr_props i_dcr_props (.clk_i, .sys_rst_i, .word_valid(lk.word_valid),
		.word_data(lk.word_data), .word_ready(lk.word_ready));
	////////////////////////////////////////////////////////////////
	// Clock, compare and verdict
	initial forever #20 clk_i = ~clk_i;
	task check(input string nm, input logic [23:0] s, input logic [23:0] x);
		tests_run++;
		if (s !== x) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, x, s);
		end
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// Model of every configuration output
	task cmp;
		logic [3:0] ep, ec, eo, er, eb, es, ev, el;
		logic [11:0] eg;
		for (int k = 0; k < 4; k++) begin
			ep[k] = c[k][8]; ec[k] = c[k][7]; eo[k] = c[k][6] | g[5]; er[k] = c[k][5];
			eb[k] = c[k][4] | g[4]; es[k] = c[k][3] & ~c[k][2]; eg[k*3+:3] = c[k][2:0];
			ev[k] = pin ^ g[12]; el[k] = clr & c[k][7];
		end
		check("glb", {pol, echo, wden, tsel, shs}, {g[12:8], g[6]});
		check("tms", tms, wd[g[9:8]]);
		check("sma", sma, g[6] ? 8 : 15);
		check("pwr", pwr, ep);
		check("clp", clp, ec);
		check("out", outn, eo);
		check("rsn", rsn, er);
		check("bst", bst, eb);
		check("spn", spn, es);
		check("rng", rng, eg);
		check("vpin", vpin, ev);
		check("cld", cld, el);
	endtask
	task rst;
		sys_rst_i = 1;
		repeat (6) @(negedge clk_i);
		sys_rst_i = 0;
		g = 0;
		c = '{0, 0, 0, 0};
	endtask
	// One command through the host end, then compare
	task send(input logic r, input logic [1:0] ch, input logic [2:0] s,
		input logic [12:0] d, input logic [4:0] rs);
		int k;
		logic [15:0] p;
		@(negedge clk_i);
		crd = r; cchip = 2'($urandom); cch = ch; csel = s; cdat = d; crs = rs; cv = 1;
		pin = 1'($urandom); clr = 1'($urandom);
		@(negedge clk_i);
		check("busy", crdy, 0);
		cv = 0;
		k = 0;
		while (cdone !== 1'b1 && k < 8) begin
			@(negedge clk_i);
			k++;
		end
		p = {s, d};
		if (!r && s == 3'h1) g = p & 16'h1F70;
		if (!r && s == 3'h2) c[ch] = p & 16'h01FF;
		check("done", cdone, 1);
		check("rdy", crdy, 1);
		check("rdq", rrq, r);
		if (r) check("rsel", rsel, rs);
		k = !r && (s == 3'h0 || s == 3'h3 || s == 3'h4);
		check("aux", aw, k);
		if (k) check("auxd", {asel, ach, adat}, {s, ch, p});
		cmp();
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence and watchdog
	initial begin
		i = $urandom(29);
		rst();
		cmp();
		for (i = 0; i < 8; i++) send(0, 2'(i), 3'h2, 13'h0188 | 13'(i), 0);
		for (i = 0; i < 4; i++) send(0, 2'(i), 3'h1, {3'h7, 2'(i), 8'hFF}, 0);
		// Outputs off first, then boosts down, before per-channel control
		send(0, 2'h0, 3'h1, 13'h0010, 0);
		send(0, 2'h0, 3'h1, 13'h0000, 0);
		repeat (60) begin
			csel = 3'($urandom % 5);
			cdat = 13'($urandom);
			if (csel == 3'h1) cdat = cdat & 13'h1FCF;
			if (csel == 3'h2 && !cdat[4]) cdat = cdat & 13'h1EBF;
			send(1'($urandom % 4 == 0), 2'($urandom), csel, cdat, 5'($urandom));
		end
		rst();
		cmp();
		send(0, 2'h1, 3'h2, 13'h1A05, 0);
		give_verdict();
	end
	initial begin
		#(40 * 3000);
		n_mismatch++;
		give_verdict();
	end
endmodule
